// ### shared/sec_defs.svh
`ifndef SEC_DEFS_SVH
`define SEC_DEFS_SVH

// register byte offsets on the apb bus
`define SEC_OFF_CMD      8'hb0
`define SEC_OFF_DATA     8'hb4

// command/status register field positions
`define SEC_BUSY_BIT     31
`define SEC_CODE_HI      30
`define SEC_CODE_LO      28
`define SEC_TOUT_BIT     9
`define SEC_LOAD_BIT     8
`define SEC_LOC_HI       7

// reset values
`define SEC_LOC_RST      8'h00
`define SEC_DATA_RST     8'h00

// operation codes written to the command field
`define SEC_CMD_READ     3'h0
`define SEC_CMD_WDIS     3'h1
`define SEC_CMD_WEN      3'h2
`define SEC_CMD_WRITE    3'h3
`define SEC_CMD_WRALL    3'h4
`define SEC_CMD_ERASE    3'h5
`define SEC_CMD_ERALL    3'h6
`define SEC_CMD_RELOAD   3'h7

// serial frame opcodes: start bit followed by two opcode bits
`define SEC_OP_READ      3'h6
`define SEC_OP_WRITE     3'h5
`define SEC_OP_ERASE     3'h7
`define SEC_OP_EXT       3'h4
`define SEC_EXT_WEN      2'h3
`define SEC_EXT_WDIS     2'h0
`define SEC_EXT_WRALL    2'h1
`define SEC_EXT_ERALL    2'h2

// frame lengths in serial clocks
`define SEC_FRAME_HDR    5'h0b
`define SEC_FRAME_FULL   5'h13

// reload image: signature byte then station address bytes
`define SEC_SIG          8'ha5
`define SEC_MAC_LAST     3'h6

// timing
`define SEC_CLK_NS       8
`define SEC_HALF_NS      500
`define SEC_HALF_CYC     ((`SEC_HALF_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)
`define SEC_TOUT_MS      30
`define SEC_TOUT_CYC     (`SEC_TOUT_MS * 1000000 / `SEC_CLK_NS)

`endif

// ### shared/sec_pkg.sv
package sec_pkg;
	// controller sequencing states
	typedef enum logic [2:0] {
		sec_idle,
		sec_shift,
		sec_gap,
		sec_poll
	} sec_state_t;
endpackage

// ### hdl/sec_shift.sv
`timescale 1ns/100ps
`include "sec_defs.svh"

module sec_shift
	import sec_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// frame request
	input  wire logic        start,
	input  wire logic [4:0]  nbits,
	input  wire logic [4:0]  nout,
	input  wire logic [18:0] tx,
	output logic             done,
	output logic [7:0]       rx,
	// serial pins
	input  wire logic        din_s,
	output logic             sclk,
	output logic             dout,
	output logic             drive_n
);
	logic [6:0]  cnt;
	logic [4:0]  left;
	logic [4:0]  oleft;
	logic [18:0] sh;
	logic        active;
	logic        tick;

	assign tick = active && (cnt == 7'(`SEC_HALF_CYC - 1));

	// half-period divider for the serial clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt <= 7'h00;
		else if (ce)
			cnt <= (start || tick) ? 7'h00 : cnt + 7'h01;
	end

	// bit shifting, sampling on the rising serial clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active  <= 1'b0;
			sclk    <= 1'b0;
			dout    <= 1'b0;
			drive_n <= 1'b1;
			sh      <= 19'h00000;
			left    <= 5'h00;
			oleft   <= 5'h00;
			rx      <= 8'h00;
			done    <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				active  <= 1'b1;
				sclk    <= 1'b0;
				sh      <= tx;
				dout    <= tx[18];
				left    <= nbits;
				oleft   <= nout;
				drive_n <= 1'b0;
			end else if (tick) begin
				if (!sclk) begin
					sclk <= 1'b1;
					rx   <= {rx[6:0], din_s};
				end else begin
					sclk  <= 1'b0;
					left  <= left - 5'h01;
					oleft <= oleft - 5'h01;
					if (oleft == 5'h01)
						drive_n <= 1'b1; // release line for returned data
					if (left == 5'h01) begin
						active  <= 1'b0;
						done    <= 1'b1;
						dout    <= 1'b0;
						drive_n <= 1'b1;
					end else begin
						sh   <= {sh[17:0], 1'b0};
						dout <= sh[17];
					end
				end
			end
		end
	end
endmodule // sec_shift

// ### hdl/sec_ctrl.sv
// Notes on behaviour
// - no answer in 30 ms: abandon, go idle
// - abandoned operation sets time-out flag bit 9
// - line pulled high: no time-out, busy clears
// - line low: only erase/write kinds time out
// - loaded flag bit 8 after valid reload
// - location from command bits 7:0, reset zero
// - data byte at 0xb4 bits 7:0
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "sec_defs.svh"

module sec_ctrl
	import sec_pkg::*;
#(
	parameter logic [21:0] TOUT_CYC = 22'(`SEC_TOUT_CYC)
) (
	// clock, reset, clock enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// serial memory pins
	output logic             mem_cs,
	output logic             mem_sclk,
	output logic             mem_data_out,
	output logic             mem_data_oe_n,
	input  wire logic        mem_data_in,
	// loaded station address
	output logic [47:0]      station_addr
);
	sec_state_t  state;
	logic        busy;
	logic [2:0]  code;
	logic        tout_flag;
	logic        loaded;
	logic [7:0]  loc;
	logic [7:0]  data_byte;
	logic [2:0]  rld_idx;
	logic [6:0]  gap_cnt;
	logic [21:0] tout_cnt;
	logic        din_m;
	logic        din_s;
	logic        fr_start;
	logic        fr_done;
	logic [7:0]  fr_rx;
	logic [4:0]  fr_nbits;
	logic [4:0]  fr_nout;
	logic [18:0] fr_tx;
	logic        wr_cmd;
	logic        wr_data;
	logic        gap_end;
	logic        finish;
	logic        rld_ok;

	// register select, used by the read and the write paths
	function automatic logic sec_hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// commands that program the array and so must wait for ready
	function automatic logic sec_polls(input logic [2:0] c);
		return (c == `SEC_CMD_WRITE) || (c == `SEC_CMD_WRALL) ||
		       (c == `SEC_CMD_ERASE) || (c == `SEC_CMD_ERALL);
	endfunction

	// serial frame image for a command, left aligned
	function automatic logic [18:0] sec_frame(input logic [2:0] c, input logic [7:0] a, input logic [7:0] d);
		case (c)
			`SEC_CMD_READ:   return {`SEC_OP_READ, a, 8'h00};
			`SEC_CMD_RELOAD: return {`SEC_OP_READ, a, 8'h00};
			`SEC_CMD_WRITE:  return {`SEC_OP_WRITE, a, d};
			`SEC_CMD_ERASE:  return {`SEC_OP_ERASE, a, 8'h00};
			`SEC_CMD_WEN:    return {`SEC_OP_EXT, `SEC_EXT_WEN, 6'h00, 8'h00};
			`SEC_CMD_WDIS:   return {`SEC_OP_EXT, `SEC_EXT_WDIS, 6'h00, 8'h00};
			`SEC_CMD_WRALL:  return {`SEC_OP_EXT, `SEC_EXT_WRALL, 6'h00, d};
			`SEC_CMD_ERALL:  return {`SEC_OP_EXT, `SEC_EXT_ERALL, 6'h00, 8'h00};
			default:         return 19'h00000;
		endcase
	endfunction

	// apb decode: zero wait, unmapped access answered with an error
	assign pready  = 1'b1;
	assign pslverr = psel && penable &&
	                 !(sec_hit(paddr, `SEC_OFF_CMD) || sec_hit(paddr, `SEC_OFF_DATA));
	assign wr_cmd  = ce && psel && penable && pwrite && sec_hit(paddr, `SEC_OFF_CMD);
	assign wr_data = ce && psel && penable && pwrite && sec_hit(paddr, `SEC_OFF_DATA);

	// read data captured in the setup phase, stable through the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (ce && psel && !penable) begin
			prdata <= 32'h00000000;
			if (sec_hit(paddr, `SEC_OFF_CMD)) begin
				prdata[`SEC_BUSY_BIT]                <= busy;
				prdata[`SEC_CODE_HI:`SEC_CODE_LO]    <= code;
				prdata[`SEC_TOUT_BIT]                <= tout_flag;
				prdata[`SEC_LOAD_BIT]                <= loaded;
				prdata[`SEC_LOC_HI:0]                <= loc;
			end else if (sec_hit(paddr, `SEC_OFF_DATA))
				prdata[`SEC_LOC_HI:0] <= data_byte;
		end
	end

	// two-flop synchroniser on the returned data line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_m <= 1'b0;
			din_s <= 1'b0;
		end else if (ce) begin
			din_m <= mem_data_in;
			din_s <= din_m;
		end
	end

	// frame parameters for the current command
	assign fr_tx    = sec_frame(code, (code == `SEC_CMD_RELOAD) ? {5'h00, rld_idx} : loc, data_byte);
	assign fr_nbits = (code == `SEC_CMD_READ || code == `SEC_CMD_RELOAD || code == `SEC_CMD_WRITE ||
	                   code == `SEC_CMD_WRALL) ? `SEC_FRAME_FULL : `SEC_FRAME_HDR;
	assign fr_nout  = (code == `SEC_CMD_WRITE || code == `SEC_CMD_WRALL) ? `SEC_FRAME_FULL : `SEC_FRAME_HDR;
	assign fr_start = ce && (state == sec_idle) && busy;
	assign gap_end  = (state == sec_gap) && (gap_cnt == 7'(`SEC_HALF_CYC - 1));
	// an operation ends after its gap, or when ready is seen while polling
	assign finish   = (gap_end && !sec_polls(code)) || ((state == sec_poll) && din_s);
	assign rld_ok   = (rld_idx != 3'h0) || (fr_rx == `SEC_SIG);

	// sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= sec_idle;
		else if (ce) begin
			case (state)
				sec_idle:
					if (busy)
						state <= sec_shift;
				sec_shift:
					if (fr_done)
						state <= sec_gap;
				sec_gap:
					if (gap_end)
						state <= sec_polls(code) ? sec_poll : sec_idle;
				sec_poll:
					if (din_s || tout_cnt == TOUT_CYC - 22'h000001)
						state <= sec_idle;
				default:
					state <= sec_idle;
			endcase
		end
	end

	// chip select: high for the frame and while polling for ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mem_cs <= 1'b0;
		else if (ce) begin
			if (fr_start || (gap_end && sec_polls(code)))
				mem_cs <= 1'b1;
			else if (fr_done || finish || state == sec_idle)
				mem_cs <= 1'b0;
		end
	end

	// gap timer between frame end and ready poll
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gap_cnt <= 7'h00;
		else if (ce)
			gap_cnt <= (state == sec_gap) ? gap_cnt + 7'h01 : 7'h00;
	end

	// no-response timer, runs only while waiting for ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tout_cnt <= 22'h000000;
		else if (ce)
			tout_cnt <= (state == sec_poll) ? tout_cnt + 22'h000001 : 22'h000000;
	end

	// busy, command code, location; reset starts the power-up reload
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b1;
			code <= `SEC_CMD_RELOAD;
			loc  <= `SEC_LOC_RST;
		end else if (ce) begin
			if (wr_cmd && !busy) begin
				busy <= pwdata[`SEC_BUSY_BIT];
				code <= pwdata[`SEC_CODE_HI:`SEC_CODE_LO];
				loc  <= pwdata[`SEC_LOC_HI:0];
			end else if (state == sec_poll && !din_s && tout_cnt == TOUT_CYC - 22'h000001)
				busy <= 1'b0;
			else if (finish && !(code == `SEC_CMD_RELOAD && rld_ok && rld_idx != `SEC_MAC_LAST))
				busy <= 1'b0;
		end
	end

	// reload byte index: signature then station address bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rld_idx <= 3'h0;
		else if (ce) begin
			if (state == sec_idle && !busy)
				rld_idx <= 3'h0;
			else if (finish && code == `SEC_CMD_RELOAD)
				rld_idx <= (rld_ok && rld_idx != `SEC_MAC_LAST) ? rld_idx + 3'h1 : 3'h0;
		end
	end

	// time-out flag: set on abandon, cleared when a new command starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tout_flag <= 1'b0;
		else if (ce) begin
			if (state == sec_poll && !din_s && tout_cnt == TOUT_CYC - 22'h000001)
				tout_flag <= 1'b1;
			else if (wr_cmd && !busy && pwdata[`SEC_BUSY_BIT])
				tout_flag <= 1'b0;
		end
	end

	// address-loaded flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			loaded <= 1'b0;
		else if (ce) begin
			if (finish && code == `SEC_CMD_RELOAD && rld_idx == `SEC_MAC_LAST)
				loaded <= 1'b1;
			else if (fr_start && code == `SEC_CMD_RELOAD && rld_idx == 3'h0)
				loaded <= 1'b0;
		end
	end

	// data byte: hardware capture of a read wins over a software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data_byte <= `SEC_DATA_RST;
		else if (ce) begin
			if (finish && code == `SEC_CMD_READ)
				data_byte <= fr_rx;
			else if (wr_data)
				data_byte <= pwdata[`SEC_LOC_HI:0];
		end
	end

	// station address bytes, one per reload index
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sta
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					station_addr[gi*8 +: 8] <= 8'h00;
				else if (ce && finish && code == `SEC_CMD_RELOAD && rld_idx == 3'(gi + 1))
					station_addr[gi*8 +: 8] <= fr_rx;
			end
		end
	endgenerate

	// serial frame engine
	sec_shift u_shift (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.start   (fr_start),
		.nbits   (fr_nbits),
		.nout    (fr_nout),
		.tx      (fr_tx),
		.done    (fr_done),
		.rx      (fr_rx),
		.din_s   (din_s),
		.sclk    (mem_sclk),
		.dout    (mem_data_out),
		.drive_n (mem_data_oe_n)
	);
endmodule // sec_ctrl

// ### testbench/sec_ctrl_props.sv
`timescale 1ns/100ps
`include "sec_defs.svh"

module sec_ctrl_props #(
	parameter logic [21:0] TOUT_CYC = 22'd200
) (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	// apb slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// serial memory pins
	input wire logic        mem_cs,
	input wire logic        mem_sclk,
	input wire logic        mem_data_out,
	input wire logic        mem_data_oe_n,
	input wire logic        mem_data_in,
	input wire logic [47:0] station_addr
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// length of the current chip-select high stretch
	logic [22:0] cs_len;
	logic        map_hit;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cs_len <= 23'h0;
		else if (!mem_cs)
			cs_len <= 23'h0;
		else if (ce)
			cs_len <= cs_len + 23'h1;
	end
	assign map_hit = paddr == `SEC_OFF_CMD || paddr == `SEC_OFF_DATA;

	// a stuck poll is given up well before this bound
	property p_cs_bound;
		cs_len < {1'b0, TOUT_CYC} + 23'd3000;
	endproperty
	a_cs_bound: assert property (p_cs_bound) else $error("chip select held too long");
	property p_data_rsvd;
		psel && penable && !pwrite && paddr == `SEC_OFF_DATA |-> prdata[31:8] == 24'h0;
	endproperty
	a_data_rsvd: assert property (p_data_rsvd) else $error("data upper bits not zero");
	property p_data_map;
		psel && penable && paddr == `SEC_OFF_DATA |-> pready && !pslverr;
	endproperty
	a_data_map: assert property (p_data_map) else $error("data register refused");
	property p_cmd_map;
		psel && penable && paddr == `SEC_OFF_CMD |-> pready && !pslverr;
	endproperty
	a_cmd_map: assert property (p_cmd_map) else $error("command register refused");
	property p_err;
		psel && penable && !map_hit |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not flagged");
	property p_err_rd;
		psel && penable && !pwrite && !map_hit |-> prdata == 32'h0;
	endproperty
	a_err_rd: assert property (p_err_rd) else $error("unmapped read not zero");
	// the data line is only driven while the memory is selected; select and drive rise on one edge
	property p_drive;
		!mem_data_oe_n |-> mem_cs;
	endproperty
	a_drive: assert property (p_drive) else $error("data line driven while deselected");
endmodule // sec_ctrl_props

bind sec_ctrl sec_ctrl_props #(.TOUT_CYC(TOUT_CYC)) u_props (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mem_cs(mem_cs), .mem_sclk(mem_sclk), .mem_data_out(mem_data_out),
	.mem_data_oe_n(mem_data_oe_n), .mem_data_in(mem_data_in), .station_addr(station_addr)
);

// ### testbench/sec_mem_model.sv
`timescale 1ns/100ps

module sec_mem_model (
	// serial pins and board options
	input wire logic cs,
	input wire logic sclk,
	input wire logic oe_n,
	input wire logic dout,
	input wire logic pull,
	input wire logic fitted,
	output logic     line
);
	logic [7:0]  mem [0:7];
	logic [18:0] sr;
	logic [2:0]  op;
	logic [2:0]  a;
	logic        drv;
	logic        bitv;
	int          cnt;
	// signature, then station address bytes
	initial begin
		for (int k = 0; k < 8; k++)
			mem[k] = (k == 0) ? 8'ha5 : 8'h10 + 8'(k);
		drv = 1'b0;
		bitv = 1'b0;
		op = 3'h0;
		a = 3'h0;
	end
	// shift in on rising serial clock
	always @(posedge sclk or negedge cs) begin
		if (!cs)
			cnt <= 0;
		else begin
			sr <= {sr[17:0], dout};
			cnt <= cnt + 1;
		end
	end
	// answer reads and store writes on falling serial clock
	always @(negedge sclk) begin
		if (cnt == 11) begin
			op = sr[10:8];
			a = sr[2:0];
		end
		drv = fitted && op == 3'h6 && cnt >= 11 && cnt < 19;
		if (drv)
			bitv = mem[a][18 - cnt];
		if (fitted && cnt == 19 && op == 3'h5)
			mem[a] = sr[7:0];
	end
	// released line falls to the board pull level
	assign line = !oe_n ? dout : (drv && cs) ? bitv : pull;
endmodule // sec_mem_model

// ### testbench/tb.sv
`timescale 1ns/100ps
`include "sec_defs.svh"

module tb;
	logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic        pull = 1, fitted = 1, pready, pslverr;
	logic        mem_cs, mem_sclk, mem_data_out, mem_data_oe_n, mem_data_in;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [47:0] station_addr;
	int          err_count = 0, total_checks = 0;
	localparam logic [47:0] MAC = 48'h161514131211;

	initial forever #4 pclk = ~pclk;

	sec_ctrl #(.TOUT_CYC(22'd200)) uut (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_cs(mem_cs), .mem_sclk(mem_sclk), .mem_data_out(mem_data_out),
		.mem_data_oe_n(mem_data_oe_n), .mem_data_in(mem_data_in), .station_addr(station_addr));
	sec_mem_model u_mem (.cs(mem_cs), .sclk(mem_sclk), .oe_n(mem_data_oe_n), .dout(mem_data_out),
		.pull(pull), .fitted(fitted), .line(mem_data_in));

	task check(input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task test_done;
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one apb transfer, held until pready is seen
	task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		int n;
		psel <= 1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		if (pready !== 1'b1) begin
			check(0, 1);
			test_done;
		end
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// poll busy, bounded
	task wait_idle;
		int i;
		for (i = 0; i < 20000; i++) begin
			apb(0, `SEC_OFF_CMD, 0);
			if (q[31] === 1'b0)
				break;
		end
		if (i == 20000) begin
			check(0, 1);
			test_done;
		end
	endtask
	task cmd(input logic [2:0] c, input logic [7:0] loc);
		apb(1, `SEC_OFF_CMD, {1'b1, c, 20'h0, loc});
		wait_idle;
	endtask

	task t_reset;
		apb(0, `SEC_OFF_DATA, 0);
		check(q, 0);
		apb(0, `SEC_OFF_CMD, 0);
		check(q[7:0], 0);
		wait_idle;
		check(q[9:8], 2'b01);
		check(station_addr, MAC);
	endtask
	task t_data;
		apb(1, `SEC_OFF_DATA, 32'hffffffff);
		apb(0, `SEC_OFF_DATA, 0);
		check(q, 32'hff);
		apb(0, 8'h40, 0);
		check(q, 0);
	endtask
	task t_rw;
		cmd(3'h2, 8'h00);
		apb(1, `SEC_OFF_DATA, 32'h3c);
		cmd(3'h3, 8'h07);
		check(q[9], 0);
		apb(1, `SEC_OFF_DATA, 0);
		cmd(3'h0, 8'h07);
		check(q[7:0], 8'h07);
		apb(0, `SEC_OFF_DATA, 0);
		check(q, 32'h3c);
	endtask
	// no memory, line pulled low: only programming codes give up
	task t_codes;
		fitted <= 0;
		pull <= 0;
		for (int c = 0; c < 7; c++) begin
			cmd(3'(c), 8'h01);
			check(q[9], c >= 3 && c <= 6);
		end
		cmd(3'h7, 8'h00);
		check(q[9:8], 2'b00);
	endtask
	task t_pullup;
		pull <= 1;
		cmd(3'h3, 8'h02);
		check(q[9], 0);
		cmd(3'h0, 8'h02);
		apb(0, `SEC_OFF_DATA, 0);
		check(q, 32'hff);
	endtask
	// clock enable low: a data register write must leave no trace
	task t_freeze;
		ce <= 0;
		apb(1, `SEC_OFF_DATA, 32'h5a);
		ce <= 1;
		apb(0, `SEC_OFF_DATA, 0);
		check(q, 32'hff);
	endtask
	task t_reload;
		fitted <= 1;
		cmd(3'h7, 8'h00);
		check(q[9:8], 2'b01);
		check(station_addr, MAC);
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		t_reset;
		t_data;
		t_rw;
		t_codes;
		t_pullup;
		t_freeze;
		t_reload;
		test_done;
	end
endmodule // tb
